// ---- include/aclc_map.svh ----
`ifndef ACLC_MAP_SVH
`define ACLC_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACLC_OFS_ENV_ONE       8'h00
`define ACLC_OFS_ENV_THREE     8'h04
`define ACLC_OFS_CMP_PRIMARY   8'h08
`define ACLC_OFS_CMP_LATCH     8'h0c
`define ACLC_OFS_MODE          8'h10
`define ACLC_OFS_IRQ_ENABLE    8'h14
`define ACLC_OFS_IRQ_CAUSE     8'h18
`define ACLC_OFS_EXT_STATUS    8'h1c
`define ACLC_OFS_SEC_STATUS    8'h20
`define ACLC_OFS_COMMAND       8'h24
`define ACLC_OFS_LATCHED_BASE  8'h28
`define ACLC_OFS_COUNTER_BASE  8'h38

// ****************************************************************
// Field positions
// ****************************************************************
`define ACLC_BIT_LATCH_POL     23
`define ACLC_BIT_BUSY_LIMIT    14
`define ACLC_BIT_CORR_BASE     24
`define ACLC_BIT_HOLD_BASE     28
`define ACLC_BIT_LTM_LO        12
`define ACLC_BIT_SPEED_SEL     14
`define ACLC_BIT_CMD_ONLY      15
`define ACLC_BIT_CLR_BASE      24
`define ACLC_BIT_INHIBIT       11
`define ACLC_BIT_LATCH_EVT     14
`define ACLC_BIT_ORIGIN_EVT    15
`define ACLC_BIT_INPUT_STATE   14

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define ACLC_LTM_LATCH_IN      2'h0
`define ACLC_LTM_ORIGIN        2'h1
`define ACLC_LTM_CMP_FOUR      2'h2
`define ACLC_LTM_CMP_FIVE      2'h3
`define ACLC_CMD_LATCH_NOW     8'h29
`define ACLC_MODE_TIMER        7'h47
`define ACLC_ABS_LIMIT         32'h00007fff
`define ACLC_REG_RESET         32'h00000000

`endif

// ---- include/aclc_pkg.sv ----
package aclc_pkg;

  typedef logic [31:0] aclc_word_t;

  typedef struct packed {
    logic [2:0]       latchSync;
    logic [2:0]       originSync;
    aclc_word_t       envOne;
    aclc_word_t       envThree;
    aclc_word_t       cmpPrimary;
    aclc_word_t       cmpLatch;
    aclc_word_t       mode;
    aclc_word_t       irqEnable;
    logic [1:0]       cause;
    aclc_word_t [3:0] counter;
    aclc_word_t [3:0] latched;
    logic             wrPend;
    logic [7:0]       wrAddr;
    aclc_word_t       rdData;
    aclc_word_t [4:0] cmpTarget;
  } aclc_state_t;

endpackage

// ---- rtl/aclc_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aclc_map.svh"

module aclc_core (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              latchTriggerInput,
  input  wire logic              originInput,
  input  wire logic [3:0]        countUp,
  input  wire logic [3:0]        countDown,
  input  wire logic              correctionActive,
  input  wire logic              axisBusyN,
  input  wire logic              cmpFourHit,
  input  wire logic              cmpFiveHit,
  input  wire aclc_pkg::aclc_word_t speedStep,
  input  wire aclc_pkg::aclc_word_t remainingPulseCount,
  input  wire aclc_pkg::aclc_word_t currentSpeedValue,
  output logic                   irqOut,
  output aclc_pkg::aclc_word_t   cmpTargetOne,
  output aclc_pkg::aclc_word_t   cmpTargetTwo,
  output aclc_pkg::aclc_word_t   cmpTargetThree,
  output aclc_pkg::aclc_word_t   cmpTargetFour,
  output aclc_pkg::aclc_word_t   cmpTargetFive
);
  import aclc_pkg::*;

  aclc_state_t s;
  aclc_state_t next_s;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Counter three is compared by magnitude, capped at the top of range.
  function automatic aclc_word_t absCap(input aclc_word_t v);
    aclc_word_t m;
    m = v[31] ? (~v + 32'h00000001) : v;
    if (m > `ACLC_ABS_LIMIT) begin
      m = `ACLC_ABS_LIMIT;
    end
    return m;
  endfunction

  function automatic aclc_word_t pickCounter(input logic [1:0] sel,
                                             input aclc_word_t [3:0] c);
    aclc_word_t r;
    case (sel)
      2'h0: r = c[0];
      2'h1: r = c[1];
      2'h2: r = absCap(c[2]);
      default: r = c[3];
    endcase
    return r;
  endfunction

  function automatic aclc_word_t stepOf(input logic up, input logic down);
    aclc_word_t r;
    if (up && !down) begin
      r = 32'h00000001;
    end else if (down && !up) begin
      r = 32'hffffffff;
    end else begin
      r = 32'h00000000;
    end
    return r;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       accept;
    logic       latchOn;
    logic       originOn;
    logic       latchEdge;
    logic       originEdge;
    logic       cmdLatch;
    logic       eventLatch;
    logic       doLatch;
    logic [3:0] countOk;
    logic       corrOk;
    logic [1:0] latch_timing_select;
    logic [2:0] c5sel;
    aclc_word_t rd;
    accept = 1'b0;
    latchOn = 1'b0;
    originOn = 1'b0;
    latchEdge = 1'b0;
    originEdge = 1'b0;
    cmdLatch = 1'b0;
    eventLatch = 1'b0;
    doLatch = 1'b0;
    countOk = 4'h0;
    corrOk = 1'b0;
    latch_timing_select = 2'h0;
    c5sel = 3'h0;
    rd = 32'h00000000;
    next_s = s;

    // Pins pass two flops; the third keeps history for edge detection.
    next_s.latchSync = {s.latchSync[1:0], latchTriggerInput};
    next_s.originSync = {s.originSync[1:0], originInput};
    // Polarity 1 makes the pin active low, so its fall is the turn-on.
    if (s.envOne[`ACLC_BIT_LATCH_POL]) begin
      latchOn = ~s.latchSync[1];
      latchEdge = ~s.latchSync[1] & s.latchSync[2];
    end else begin
      latchOn = s.latchSync[1];
      latchEdge = s.latchSync[1] & ~s.latchSync[2];
    end
    originOn = s.originSync[1];
    originEdge = s.originSync[1] & ~s.originSync[2];

    // ****************************************************************
    // Bus data phase: register writes land here; counter writes land in the counter loop
    // ****************************************************************
    if (s.wrPend) begin
      case (s.wrAddr)
        `ACLC_OFS_ENV_ONE:     next_s.envOne = hwdata;
        `ACLC_OFS_ENV_THREE:   next_s.envThree = hwdata;
        `ACLC_OFS_CMP_PRIMARY: next_s.cmpPrimary = hwdata;
        `ACLC_OFS_CMP_LATCH:   next_s.cmpLatch = hwdata;
        `ACLC_OFS_MODE:        next_s.mode = hwdata;
        `ACLC_OFS_IRQ_ENABLE:  next_s.irqEnable = hwdata;
        `ACLC_OFS_IRQ_CAUSE: begin
          // Write one to clear; a new event below still wins.
          next_s.cause = s.cause & ~hwdata[`ACLC_BIT_ORIGIN_EVT:`ACLC_BIT_LATCH_EVT];
        end
        `ACLC_OFS_COMMAND: begin
          cmdLatch = (hwdata[7:0] == `ACLC_CMD_LATCH_NOW);
        end
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // Latch
    // ****************************************************************
    latch_timing_select = s.cmpLatch[`ACLC_BIT_LTM_LO+1:`ACLC_BIT_LTM_LO];
    case (latch_timing_select)
      `ACLC_LTM_LATCH_IN: eventLatch = latchEdge;
      `ACLC_LTM_ORIGIN:   eventLatch = originEdge;
      `ACLC_LTM_CMP_FOUR: eventLatch = cmpFourHit;
      default:            eventLatch = cmpFiveHit;
    endcase
    // The pulse-width floor on the pin is met by the two-flop sampler.
    doLatch = cmdLatch | (eventLatch & ~s.cmpLatch[`ACLC_BIT_CMD_ONLY]);
    if (doLatch) begin
      next_s.latched = s.counter;
      if (s.cmpLatch[`ACLC_BIT_SPEED_SEL]) begin
        next_s.latched[2] = speedStep;
      end
    end

    // ****************************************************************
    // Counters
    // ****************************************************************
    for (int i = 0; i < 4; i++) begin
      corrOk = ~correctionActive | s.envThree[`ACLC_BIT_CORR_BASE + i];
      if (i == 0) begin
        countOk[i] = corrOk
                   & (s.mode[6:0] != `ACLC_MODE_TIMER)
                   & ~s.mode[`ACLC_BIT_INHIBIT];
      end else begin
        countOk[i] = corrOk & ~s.envThree[`ACLC_BIT_HOLD_BASE + i];
      end
      if (i == 3 && s.envThree[`ACLC_BIT_BUSY_LIMIT]) begin
        countOk[i] = countOk[i] & ~axisBusyN;
      end
      if (doLatch && s.cmpLatch[`ACLC_BIT_CLR_BASE + i]) begin
        // Clearing keeps this cycle's pulse if the counter may count, so it ends at its step (one for an up pulse); a held counter ends at zero.
        next_s.counter[i] = countOk[i] ? stepOf(countUp[i], countDown[i])
                                       : 32'h00000000;
      end else if (countOk[i]) begin
        next_s.counter[i] = s.counter[i] + stepOf(countUp[i], countDown[i]);
      end
      if (s.wrPend && s.wrAddr == (`ACLC_OFS_COUNTER_BASE + 8'(i * 4))) begin
        next_s.counter[i] = hwdata;
      end
    end

    // ****************************************************************
    // Event flags: set wins over clear
    // ****************************************************************
    if (latchEdge && latch_timing_select == `ACLC_LTM_LATCH_IN) begin
      next_s.cause[0] = 1'b1;
    end
    if (originEdge && latch_timing_select == `ACLC_LTM_ORIGIN) begin
      next_s.cause[1] = 1'b1;
    end

    // ****************************************************************
    // Comparator sources
    // ****************************************************************
    for (int k = 0; k < 4; k++) begin
      next_s.cmpTarget[k] = pickCounter(s.cmpPrimary[k*8 +: 2], s.counter);
    end
    c5sel = s.cmpLatch[2:0];
    case (c5sel)
      3'h4:    next_s.cmpTarget[4] = remainingPulseCount;
      3'h5:    next_s.cmpTarget[4] = currentSpeedValue;
      3'h6:    next_s.cmpTarget[4] = 32'h00000000;
      3'h7:    next_s.cmpTarget[4] = 32'h00000000;
      default: next_s.cmpTarget[4] = pickCounter(c5sel[1:0], s.counter);
    endcase

    // ****************************************************************
    // Bus address phase: reads are decoded from the updated state, except pin status, which uses the current samples
    // ****************************************************************
    accept = hsel & htrans[1] & hready;
    next_s.wrPend = accept & hwrite;
    next_s.wrAddr = accept ? haddr[7:0] : 8'h00;
    if (accept && !hwrite) begin
      case (haddr[7:0])
        `ACLC_OFS_ENV_ONE:     rd = next_s.envOne;
        `ACLC_OFS_ENV_THREE:   rd = next_s.envThree;
        `ACLC_OFS_CMP_PRIMARY: rd = next_s.cmpPrimary;
        `ACLC_OFS_CMP_LATCH:   rd = next_s.cmpLatch;
        `ACLC_OFS_MODE:        rd = next_s.mode;
        `ACLC_OFS_IRQ_ENABLE:  rd = next_s.irqEnable;
        `ACLC_OFS_IRQ_CAUSE: begin
          rd[`ACLC_BIT_ORIGIN_EVT:`ACLC_BIT_LATCH_EVT] = next_s.cause;
        end
        `ACLC_OFS_EXT_STATUS:  rd[`ACLC_BIT_INPUT_STATE] = latchOn;
        `ACLC_OFS_SEC_STATUS:  rd[`ACLC_BIT_INPUT_STATE] = originOn;
        default: begin
          for (int j = 0; j < 4; j++) begin
            if (haddr[7:0] == `ACLC_OFS_LATCHED_BASE + 8'(j * 4)) begin
              rd = next_s.latched[j];
            end
            if (haddr[7:0] == `ACLC_OFS_COUNTER_BASE + 8'(j * 4)) begin
              rd = next_s.counter[j];
            end
          end
        end
      endcase
      next_s.rdData = rd;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.envOne <= `ACLC_REG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The slave never stretches a transfer, so the bus runs at full rate.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdData;
  assign irqOut = |(s.cause & s.irqEnable[`ACLC_BIT_ORIGIN_EVT:`ACLC_BIT_LATCH_EVT]);
  assign cmpTargetOne = s.cmpTarget[0];
  assign cmpTargetTwo = s.cmpTarget[1];
  assign cmpTargetThree = s.cmpTarget[2];
  assign cmpTargetFour = s.cmpTarget[3];
  assign cmpTargetFive = s.cmpTarget[4];

endmodule

`default_nettype wire

// ---- testbench/aclc_core_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Bus and event checks
// ****
module aclc_core_assertions (
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [31:0]          hwdata,
  input wire logic [31:0]          hrdata,
  input wire logic                 latchTriggerInput,
  input wire logic                 originInput,
  input wire logic                 irqOut,
  input wire aclc_pkg::aclc_word_t cmpTargetOne
);
  import aclc_pkg::*;
  logic       take;
  logic       envWr;
  logic [2:0] wrHist;
  logic [3:0] quiet;
  logic [1:0] pinPrev;
  aclc_word_t envShadow;
  assign take = hsel & htrans[1] & hready;
  // The interrupt may only move soon after a pin change or a host write.
  always_ff @(posedge ref_clk) begin
    pinPrev <= {originInput, latchTriggerInput};
    wrHist <= {wrHist[1:0], take & hwrite};
    envWr <= take & hwrite & (haddr[7:0] == 8'h00);
    if (!rst_n) begin
      envShadow <= 32'h0;
    end else if (envWr) begin
      envShadow <= hwdata;
    end
    if (!rst_n || pinPrev != {originInput, latchTriggerInput}) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  sequence readTaken;
    take && !hwrite;
  endsequence
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_bus_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  chk_read_data_stands: assert property (!(take && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_unmapped_read_zero: assert property (readTaken ##0 (haddr[7:0] >= 8'h48) |=> hrdata == 0)
    else $error("unmapped read not zero");
  chk_polarity_read_back: assert property (readTaken ##0 (haddr[7:0] == 8'h00) |=>
    hrdata == envShadow) else $error("environment register read back wrong");
  chk_reset_leaves_zero: assert property ($rose(rst_n) |-> hrdata == 32'h0 && !irqOut)
    else $error("outputs not clear after reset");
  chk_reset_target_zero: assert property ($rose(rst_n) |-> cmpTargetOne == 32'h0)
    else $error("target not clear after reset");
  chk_irq_rise_cause: assert property ($rose(irqOut) |-> quiet < 4'h8 || wrHist != 3'h0)
    else $error("interrupt rose without cause");
  chk_irq_fall_write: assert property ($fell(irqOut) |-> wrHist != 3'h0)
    else $error("interrupt fell without host write");
endmodule
`default_nettype wire

// ---- testbench/aclc_sensor_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Latch and origin sensors
// ****
module aclc_sensor_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] fire,
  input  wire logic [7:0] holdCycles,
  input  wire logic       activeLow,
  output logic            latchTriggerInput,
  output logic            originInput
);
  logic [7:0] latchLeft = 8'h00;
  logic [7:0] originLeft = 8'h00;
  logic [7:0] span;
  // A pulse under two clocks may be missed by the device, so none is ever sent.
  assign span = (holdCycles < 8'h02) ? 8'h02 : holdCycles;
  always @(posedge ref_clk) begin
    if (fire[0]) begin
      latchLeft <= span;
    end else if (latchLeft != 8'h00) begin
      latchLeft <= latchLeft - 8'h01;
    end
    if (fire[1]) begin
      originLeft <= span;
    end else if (originLeft != 8'h00) begin
      originLeft <= originLeft - 8'h01;
    end
  end
  assign latchTriggerInput = (latchLeft != 8'h00) ^ activeLow;
  assign originInput = originLeft != 8'h00;
endmodule
`default_nettype wire

// ---- testbench/tb_aclc_core.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// Register-level bench
// ****
module tb_aclc_core;
  import aclc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  countUp = 4'h0;
  logic [3:0]  countDown = 4'h0;
  logic        corr = 1'b0;
  logic        busyN = 1'b1;
  logic        hitFour = 1'b0;
  logic        hitFive = 1'b0;
  logic [1:0]  fire = 2'h0;
  logic [7:0]  hold = 8'h03;
  logic        actLow = 1'b0;
  logic        hreadyout, hresp, irqOut, latchIn, originIn;
  aclc_word_t  hwdata = 32'h0;
  aclc_word_t  speed = 32'h77;
  aclc_word_t  remain = 32'h1234;
  aclc_word_t  curSpeed = 32'h5678;
  aclc_word_t  hrdata, got, tOne, tTwo, tThree, tFour, tFive;
  aclc_word_t  cv [4] = '{32'h11, 32'h22, 32'hfffffffb, 32'h44};
  int          errCount = 0;
  int          totalChecks = 0;
  initial forever #20 ref_clk = ~ref_clk;
  aclc_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .latchTriggerInput(latchIn), .originInput(originIn),
    .countUp(countUp), .countDown(countDown), .correctionActive(corr), .axisBusyN(busyN),
    .cmpFourHit(hitFour), .cmpFiveHit(hitFive), .speedStep(speed), .remainingPulseCount(remain),
    .currentSpeedValue(curSpeed), .irqOut(irqOut), .cmpTargetOne(tOne), .cmpTargetTwo(tTwo),
    .cmpTargetThree(tThree), .cmpTargetFour(tFour), .cmpTargetFive(tFive));
  aclc_sensor_model u_sensor (.ref_clk(ref_clk), .fire(fire), .holdCycles(hold),
    .activeLow(actLow), .latchTriggerInput(latchIn), .originInput(originIn));
  task automatic chk(input string what, input aclc_word_t seen, input aclc_word_t exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input aclc_word_t d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    got = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input aclc_word_t d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input aclc_word_t e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), got, e);
  endtask
  task automatic strike(input logic [1:0] f, input logic [1:0] h);
    @(posedge ref_clk);
    fire <= f;
    {hitFive, hitFour} <= h;
    @(posedge ref_clk);
    fire <= 2'h0;
    {hitFive, hitFour} <= 2'h0;
  endtask
  task automatic cnt(input logic [7:0] a, input aclc_word_t v, input logic [7:0] ca,
                     input logic [3:0] m, input logic c, input logic b, input aclc_word_t e);
    wr(a, v);
    wr(ca, 32'h0);
    corr <= c;
    busyN <= b;
    repeat (5) begin
      @(posedge ref_clk);
      countUp <= m;
      @(posedge ref_clk);
      countUp <= 4'h0;
    end
    rd(ca, e);
    corr <= 1'b0;
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    tick(30000);
    errCount++;
    giveVerdict;
  end
  initial begin
    tick(10);
    rst_n <= 1'b1;
    for (int a = 0; a < 32'h48; a += 4) begin
      rd(8'(a), 32'h0);
    end
    rd(8'h80, 32'h0);
    cnt(8'h10, 32'h47, 8'h38, 4'h1, 1'b0, 1'b1, 32'h0);
    cnt(8'h10, 32'h800, 8'h38, 4'h1, 1'b0, 1'b1, 32'h0);
    cnt(8'h10, 32'h0, 8'h38, 4'h1, 1'b0, 1'b1, 32'h5);
    cnt(8'h04, 32'h0, 8'h3c, 4'h2, 1'b1, 1'b1, 32'h0);
    cnt(8'h04, 32'h02000000, 8'h3c, 4'h2, 1'b1, 1'b1, 32'h5);
    cnt(8'h04, 32'h20000000, 8'h3c, 4'h2, 1'b0, 1'b1, 32'h0);
    cnt(8'h04, 32'h40000000, 8'h40, 4'h4, 1'b0, 1'b1, 32'h0);
    cnt(8'h04, 32'h00004000, 8'h44, 4'h8, 1'b0, 1'b1, 32'h0);
    cnt(8'h04, 32'h00004000, 8'h44, 4'h8, 1'b0, 1'b0, 32'h5);
    for (int i = 0; i < 4; i++) begin
      wr(8'(32'h38 + i * 4), cv[i]);
    end
    wr(8'h08, 32'h03020100);
    wr(8'h0c, 32'h2);
    tick(3);
    chk("t1", tOne, 32'h11);
    chk("t2", tTwo, 32'h22);
    chk("t3", tThree, 32'h5);
    chk("t4", tFour, 32'h44);
    chk("t5", tFive, 32'h5);
    wr(8'h0c, 32'h4);
    tick(3);
    chk("t5", tFive, remain);
    wr(8'h0c, 32'h5);
    wr(8'h08, 32'h00010203);
    tick(3);
    chk("t5", tFive, curSpeed);
    chk("t1", tOne, 32'h44);
    chk("t4", tFour, 32'h11);
    wr(8'h24, 32'h29);
    for (int i = 0; i < 4; i++) begin
      rd(8'(32'h28 + i * 4), cv[i]);
    end
    wr(8'h0c, 32'h4000);
    wr(8'h24, 32'h29);
    rd(8'h30, speed);
    wr(8'h0c, 32'h0f008000);
    wr(8'h24, 32'h29);
    for (int i = 0; i < 4; i++) begin
      rd(8'(32'h38 + i * 4), 32'h0);
    end
    wr(8'h38, 32'h99);
    strike(2'h1, 2'h0);
    tick(8);
    rd(8'h28, 32'h11);
    wr(8'h14, 32'hc000);
    for (int m = 0; m < 4; m++) begin
      wr(8'h0c, 32'(m) << 12);
      wr(8'h38, 32'h100 + 32'(m));
      wr(8'h18, 32'hc000);
      strike(2'(m < 2 ? 1 << m : 0), 2'(m < 2 ? 0 : 1 << (m - 2)));
      tick(8);
      rd(8'h28, 32'h100 + 32'(m));
      rd(8'h18, m == 0 ? 32'h4000 : m == 1 ? 32'h8000 : 32'h0);
      chk("irq", {31'h0, irqOut}, m < 2 ? 32'h1 : 32'h0);
      wr(8'h18, 32'hc000);
    end
    wr(8'h0c, 32'h01002000);
    wr(8'h38, 32'h300);
    @(posedge ref_clk);
    countUp <= 4'h1;
    hitFour <= 1'b1;
    @(posedge ref_clk);
    countUp <= 4'h0;
    hitFour <= 1'b0;
    rd(8'h38, 32'h1);
    rd(8'h28, 32'h300);
    actLow <= 1'b1;
    wr(8'h00, 32'h00800000);
    wr(8'h0c, 32'h0);
    wr(8'h38, 32'h200);
    hold <= 8'h28;
    strike(2'h1, 2'h0);
    tick(8);
    rd(8'h28, 32'h200);
    rd(8'h1c, 32'h4000);
    strike(2'h2, 2'h0);
    tick(8);
    rd(8'h20, 32'h4000);
    giveVerdict;
  end
endmodule
bind aclc_core aclc_core_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hwdata(hwdata), .hrdata(hrdata), .latchTriggerInput(latchTriggerInput),
  .originInput(originInput), .irqOut(irqOut), .cmpTargetOne(cmpTargetOne));
`default_nettype wire
